// >>> design/sfpe_page_ram.sv
// Page load buffer: 256 bytes, one write port, registered read port
module sfpe_page_ram (
  // Clock
  input wire logic clk,
  // Write side
  input wire logic wr_en,
  input wire logic [7:0] wr_addr,
  input wire logic [7:0] wr_data,
  // Read side
  input wire logic [7:0] rd_addr,
  output logic [7:0] rd_data
);
  logic [7:0] mem [0:255];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule // sfpe_page_ram

// >>> design/sfpe_pkg.sv
// Constants and types shared by the serial flash program and erase block
package sfpe_pkg;
  // Opcodes
  localparam logic [7:0] OP_CHIP_ERASE = 8'hc7;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h0a;
  localparam logic [7:0] OP_ID_READ = 8'h9f;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  // Identification bytes; the two code values are arbitrary
  localparam logic [7:0] ID_MAKER_CODE = 8'ha5;
  localparam logic [7:0] ID_PART_CODE = 8'h3c;
  localparam logic [7:0] ID_FILLER = 8'h00;
  localparam logic [1:0] ID_LAST_IDX = 2'h2;
  // Frame layout in bytes
  localparam logic [2:0] BYTE_OPCODE = 3'h0;
  localparam logic [2:0] BYTE_ADDR_HI = 3'h1;
  localparam logic [2:0] BYTE_ADDR_MID = 3'h2;
  localparam logic [2:0] BYTE_ADDR_LO = 3'h3;
  localparam logic [2:0] BYTE_DATA = 3'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Status byte fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_WEN_BIT = 1;
  // Page geometry
  localparam int ADDR_W = 19;
  localparam int PAGE_W = 11;
  localparam int PAGE_BYTES = 256;
  localparam logic [8:0] PAGE_FULL = 9'h100;
  localparam logic [8:0] WALK_END = 9'h101;
  // Protected region: pages 0..255, i.e. address bits 18:16 all zero
  localparam logic [2:0] PROT_TOP_BITS = 3'h0;
  // Timing
  localparam int CLK_MHZ = 100;
  localparam int CE_TYP_MS = 300;
  localparam int CE_MAX_MS = 5000;
  localparam int CE_CYC = CE_TYP_MS * 1000 * CLK_MHZ;
  localparam int PP_BASE_US = 40;
  localparam int PP_SPAN_US = 1460;
  localparam int PP_MAX_US = 2500;
  localparam int PP_BASE_CYC = PP_BASE_US * CLK_MHZ;
  localparam int PP_BYTE_CYC = PP_SPAN_US * CLK_MHZ / PAGE_BYTES;
  localparam int PW_TYP_US = 11000;
  localparam int PW_MAX_US = 22500;
  localparam int PW_CYC = PW_TYP_US * CLK_MHZ;
  // Reset values
  localparam logic WEN_RESET = 1'b0;
  localparam logic [31:0] TMR_RESET = 32'h0;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_COMMIT = 2'b01,
    ST_WAIT = 2'b11,
    ST_ERASE = 2'b10
  } sfpe_state_e;

  typedef enum logic [1:0] {
    OUT_NONE = 2'b00,
    OUT_ID = 2'b01,
    OUT_STATUS = 2'b11
  } sfpe_out_e;

  // One write into the cell array
  typedef struct packed {
    logic we;
    logic rewrite;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } sfpe_arr_wr_s;
endpackage : sfpe_pkg

// >>> design/sfpe_top.sv
// Serial flash command sequencer: erase, program, rewrite, identification
module sfpe_top #(
  parameter int CE_CYCLES = sfpe_pkg::CE_CYC,
  parameter int PW_CYCLES = sfpe_pkg::PW_CYC
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Serial link pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  output logic SO,
  output logic SO_OE,
  // Control pins
  input wire logic RESET_N,
  input wire logic WP_N,
  // Status
  output logic BUSY,
  output logic WEN,
  // Cell array
  output sfpe_pkg::sfpe_arr_wr_s ARR_WR,
  output logic ARR_ERASE_ALL
);
  import sfpe_pkg::*;

  // Pin synchronisers: stage one is read only by stage two
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic sck_d_r;
  logic cs_n_d_r;
  logic cs_s1_r;
  logic cs_n_s;

  always_ff @(posedge REF_CLK) begin
    pin_s1_r <= {WP_N, RESET_N, SI, SCK};
    pin_s2_r <= pin_s1_r;
    sck_d_r <= pin_s2_r[0];
    cs_n_d_r <= cs_n_s;
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cs_s1_r <= 1'b1;
    end else begin
      cs_s1_r <= CS_N;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cs_n_s <= 1'b1;
    end else begin
      cs_n_s <= cs_s1_r;
    end
  end

  logic sck_s, si_s, rst_pin_n_s, wp_n_s;
  logic sck_rise, sck_fall, cs_fall, cs_rise;
  assign sck_s = pin_s2_r[0];
  assign si_s = pin_s2_r[1];
  assign rst_pin_n_s = pin_s2_r[2];
  assign wp_n_s = pin_s2_r[3];
  assign sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
  assign sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
  assign cs_fall = ~cs_n_s & cs_n_d_r;
  assign cs_rise = cs_n_s & ~cs_n_d_r;

  sfpe_state_e st_r;
  logic busy;
  logic hw_reset;
  assign busy = (st_r != ST_IDLE);
  // The pin only acts while nothing is being written
  assign hw_reset = ~rst_pin_n_s & ~busy;

  // Frame reception
  logic [7:0] shreg_r;
  logic [2:0] bit_cnt_r;
  logic [2:0] byte_cnt_r;
  logic [7:0] opcode_r;
  logic [ADDR_W-1:0] addr_r;
  logic [8:0] nbytes_r;
  logic [PAGE_BYTES-1:0] valid_r;
  logic [7:0] byte_in;
  logic byte_done;
  logic buf_wr;

  assign byte_in = {shreg_r[6:0], si_s};
  assign byte_done = sck_rise & (bit_cnt_r == LAST_BIT);
  // Buffer only loads while idle so a commit walk never sees new bytes
  assign buf_wr = byte_done & (byte_cnt_r == BYTE_DATA) & ~busy
    & ((opcode_r == OP_PAGE_PROG) | (opcode_r == OP_PAGE_WRITE));

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || hw_reset || cs_fall) begin
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= BYTE_OPCODE;
      shreg_r <= 8'h00;
    end else if (sck_rise) begin
      shreg_r <= byte_in;
      bit_cnt_r <= bit_cnt_r + 3'h1;
      if (byte_done && byte_cnt_r != BYTE_DATA) begin
        byte_cnt_r <= byte_cnt_r + 3'h1;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || hw_reset) begin
      opcode_r <= 8'h00;
      addr_r <= '0;
    end else if (byte_done) begin
      case (byte_cnt_r)
        BYTE_OPCODE: begin
          opcode_r <= byte_in;
        end
        BYTE_ADDR_HI: begin
          addr_r[18:16] <= byte_in[2:0];
        end
        BYTE_ADDR_MID: begin
          addr_r[15:8] <= byte_in;
        end
        BYTE_ADDR_LO: begin
          addr_r[7:0] <= byte_in;
        end
        default: begin
          if (buf_wr) begin
            // Page bits stay, low byte rolls over within the page
            addr_r[7:0] <= addr_r[7:0] + 8'h01;
          end
        end
      endcase
    end
  end

  // Later bytes overwrite earlier ones at the same slot
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || hw_reset || (cs_fall && !busy)) begin
      valid_r <= '0;
      nbytes_r <= 9'h000;
    end else if (buf_wr) begin
      valid_r[addr_r[7:0]] <= 1'b1;
      if (nbytes_r != PAGE_FULL) begin
        nbytes_r <= nbytes_r + 9'h001;
      end
    end
  end

  // Command acceptance at deselect
  logic whole_bytes;
  logic frame_one_byte;
  logic page_guarded;
  logic go_erase;
  logic go_page;
  logic go_wen_set;
  logic go_wen_clr;

  assign whole_bytes = (bit_cnt_r == 3'h0);
  assign frame_one_byte = whole_bytes & (byte_cnt_r == BYTE_ADDR_HI);
  assign page_guarded = ~wp_n_s
    & (addr_r[ADDR_W-1:ADDR_W-3] == PROT_TOP_BITS);
  // Write enable must be set, else nothing changes
  assign go_erase = cs_rise & ~busy & ~hw_reset & WEN & frame_one_byte
    & (opcode_r == OP_CHIP_ERASE) & wp_n_s;
  assign go_page = cs_rise & ~busy & ~hw_reset & WEN & whole_bytes
    & (byte_cnt_r == BYTE_DATA) & (nbytes_r != 9'h000) & ~page_guarded
    & ((opcode_r == OP_PAGE_PROG) | (opcode_r == OP_PAGE_WRITE));
  assign go_wen_set = cs_rise & ~busy & frame_one_byte
    & (opcode_r == OP_WRITE_EN);
  assign go_wen_clr = cs_rise & ~busy & frame_one_byte
    & (opcode_r == OP_WRITE_DIS);

  // Write operation sequencer
  logic [31:0] tmr_r;
  logic [8:0] walk_r;
  logic rewrite_r;
  logic [PAGE_W-1:0] page_r;
  logic [7:0] rd_data;
  logic [7:0] widx_r;
  logic wv_r;
  logic [31:0] prog_cyc;

  // Time grows with byte count: base plus a share per byte
  assign prog_cyc = 32'(PP_BASE_CYC) + 32'(nbytes_r) * 32'(PP_BYTE_CYC);

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      st_r <= ST_IDLE;
      tmr_r <= TMR_RESET;
      walk_r <= 9'h000;
      rewrite_r <= 1'b0;
      page_r <= '0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          walk_r <= 9'h000;
          if (go_erase) begin
            st_r <= ST_ERASE;
            tmr_r <= 32'(CE_CYCLES);
          end else if (go_page) begin
            st_r <= ST_COMMIT;
            rewrite_r <= (opcode_r == OP_PAGE_WRITE);
            page_r <= addr_r[ADDR_W-1:8];
          end
        end
        ST_COMMIT: begin
          walk_r <= walk_r + 9'h001;
          if (walk_r == WALK_END) begin
            st_r <= ST_WAIT;
            tmr_r <= rewrite_r ? 32'(PW_CYCLES) : prog_cyc;
          end
        end
        ST_WAIT, ST_ERASE: begin
          // Finishes on its own, no host action needed
          if (tmr_r <= 32'h1) begin
            st_r <= ST_IDLE;
            tmr_r <= TMR_RESET;
          end else begin
            tmr_r <= tmr_r - 32'h1;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  sfpe_page_ram u_page_ram (
    .clk(REF_CLK),
    .wr_en(buf_wr),
    .wr_addr(addr_r[7:0]),
    .wr_data(byte_in),
    .rd_addr(walk_r[7:0]),
    .rd_data(rd_data)
  );

  // Walk the buffer; only loaded slots reach the array
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      wv_r <= 1'b0;
      widx_r <= 8'h00;
    end else begin
      wv_r <= (st_r == ST_COMMIT) & ~walk_r[8] & valid_r[walk_r[7:0]];
      widx_r <= walk_r[7:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      ARR_WR <= '0;
      ARR_ERASE_ALL <= 1'b0;
    end else begin
      ARR_WR.we <= wv_r;
      ARR_WR.rewrite <= rewrite_r;
      ARR_WR.addr <= {page_r, widx_r};
      ARR_WR.wdata <= rd_data;
      ARR_ERASE_ALL <= go_erase;
    end
  end

  // Write enable latch
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || hw_reset) begin
      WEN <= WEN_RESET;
    end else if (busy && tmr_r == 32'h1) begin
      WEN <= 1'b0;
    end else if (go_wen_set) begin
      WEN <= 1'b1;
    end else if (go_wen_clr) begin
      WEN <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      BUSY <= 1'b0;
    end else begin
      BUSY <= busy;
    end
  end

  // Serial output
  sfpe_out_e out_mode_r;
  logic [2:0] out_bit_r;
  logic [1:0] id_idx_r;
  logic [7:0] out_byte;
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[STAT_BUSY_BIT] = busy;
    status_byte[STAT_WEN_BIT] = WEN;
  end

  always_comb begin
    case (id_idx_r)
      2'h0: out_byte = ID_MAKER_CODE;
      2'h1: out_byte = ID_PART_CODE;
      default: out_byte = ID_FILLER;
    endcase
    if (out_mode_r == OUT_STATUS) begin
      out_byte = status_byte;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || hw_reset || cs_n_s) begin
      out_mode_r <= OUT_NONE;
    end else if (byte_done && byte_cnt_r == BYTE_OPCODE) begin
      if (byte_in == OP_ID_READ && !busy) begin
        out_mode_r <= OUT_ID;
      end else if (byte_in == OP_STATUS_READ) begin
        out_mode_r <= OUT_STATUS;
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || out_mode_r == OUT_NONE) begin
      out_bit_r <= LAST_BIT;
      id_idx_r <= 2'h0;
    end else if (sck_fall) begin
      out_bit_r <= out_bit_r - 3'h1;
      if (out_bit_r == 3'h0) begin
        id_idx_r <= (id_idx_r == ID_LAST_IDX) ? 2'h0 : id_idx_r + 2'h1;
      end
    end
  end

  // Driver released during reset and deselect
  always_ff @(posedge REF_CLK) begin
    if (SYS_RST || hw_reset || out_mode_r == OUT_NONE) begin
      SO <= 1'b0;
      SO_OE <= 1'b0;
    end else if (sck_fall) begin
      SO <= out_byte[out_bit_r];
      SO_OE <= 1'b1;
    end
  end
endmodule // sfpe_top

// >>> tb/sfpe_host.sv
// Serial host model: mode 0, clock still outside frames
module sfpe_host (
  // Clock
  input wire logic clk,
  // Link
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last;
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    last = 1'b0;
  end
  // Half of the 160 ns link period
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  task automatic sel();
    @(negedge clk);
    cs_n = 1'b0;
    half();
  endtask
  task automatic desel();
    half();
    cs_n = 1'b1;
    si = ~si;
    repeat (8) @(negedge clk);
  endtask
  // A released line reads as the inverse of its last level
  task automatic xb(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      half();
      sck = 1'b1;
      last = so_oe ? so : ~last;
      rx[i] = last;
      half();
      sck = 1'b0;
    end
  endtask
endmodule // sfpe_host

// >>> tb/sfpe_sva.sv
// Port assertions for the serial flash command sequencer
module sfpe_sva #(
  parameter int CE_CYCLES = 200
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic SYS_RST,
  // Serial link pins
  input wire logic CS_N,
  input wire logic SCK,
  input wire logic SI,
  input wire logic SO,
  input wire logic SO_OE,
  // Control pins
  input wire logic RESET_N,
  input wire logic WP_N,
  // Status and array
  input wire logic BUSY,
  input wire logic WEN,
  input wire sfpe_pkg::sfpe_arr_wr_s ARR_WR,
  input wire logic ARR_ERASE_ALL
);
  import sfpe_pkg::*;
  localparam int CE_LO = CE_CYCLES - 2;
  default clocking dc @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  property p_erase_one;
    ARR_ERASE_ALL |=> !ARR_ERASE_ALL;
  endproperty
  a_erase_one: assert property (p_erase_one) else $error("erase");
  property p_erase_len;
    ARR_ERASE_ALL |=> (BUSY throughout ##CE_LO 1'b1) ##[1:40] !BUSY;
  endproperty
  a_erase_len: assert property (p_erase_len) else $error("len");
  // Pin is synced, so only a settled low level is judged
  property p_wp_erase;
    (!WP_N) [*8] |=> !ARR_ERASE_ALL;
  endproperty
  a_wp_erase: assert property (p_wp_erase) else $error("wp erase");
  property p_wp_prot;
    (!WP_N) [*8] ##1 ARR_WR.we |-> ARR_WR.addr[18:16] != PROT_TOP_BITS;
  endproperty
  a_wp_prot: assert property (p_wp_prot) else $error("wp page");
  property p_we_busy;
    ARR_WR.we |-> BUSY;
  endproperty
  a_we_busy: assert property (p_we_busy) else $error("we idle");
  property p_start_wen;
    $rose(BUSY) |-> WEN;
  endproperty
  a_start_wen: assert property (p_start_wen) else $error("no wen");
  property p_end_wen;
    $fell(BUSY) |-> !WEN;
  endproperty
  a_end_wen: assert property (p_end_wen) else $error("wen kept");
  property p_rst_oe;
    (!RESET_N && !BUSY) [*6] |=> !SO_OE;
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("so in rst");
  property p_rst_wen;
    (!RESET_N && !BUSY) [*6] |=> !WEN;
  endproperty
  a_rst_wen: assert property (p_rst_wen) else $error("wen rst");
  property p_cs_oe;
    CS_N [*6] |=> !SO_OE;
  endproperty
  a_cs_oe: assert property (p_cs_oe) else $error("so kept");
  c_erase: cover property (ARR_ERASE_ALL);
  c_rewrite: cover property (ARR_WR.we && ARR_WR.rewrite);
  c_out: cover property ($rose(SO_OE));
endmodule // sfpe_sva

bind sfpe_top sfpe_sva #(.CE_CYCLES(CE_CYCLES)) sfpe_sva_i (
  .REF_CLK(REF_CLK), .SYS_RST(SYS_RST), .CS_N(CS_N), .SCK(SCK), .SI(SI),
  .SO(SO), .SO_OE(SO_OE), .RESET_N(RESET_N), .WP_N(WP_N), .BUSY(BUSY),
  .WEN(WEN), .ARR_WR(ARR_WR), .ARR_ERASE_ALL(ARR_ERASE_ALL)
);

// >>> tb/tb.sv
// Self-checking bench for the serial flash command sequencer
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfpe_pkg::*;
  logic clk = 0, rst = 1, rst_n = 1, wp_n = 1;
  logic cs_n, sck, si, so, so_oe, busy, wen, erase_all;
  sfpe_arr_wr_s arr_wr;
  sfpe_arr_wr_s exp_q[$];
  int errors = 0, num_checks = 0, cyc = 0, blen = 0, blen_last = 0;
  int n_erase = 0;
  logic [7:0] rx;
  logic [18:0] a;
  logic [7:0] dat[258];
  logic [7:0] id_t[3];
  initial forever #5 clk = ~clk;
  sfpe_top #(.CE_CYCLES(200), .PW_CYCLES(300)) sfpe_top_i (
    .REF_CLK(clk), .SYS_RST(rst), .CS_N(cs_n), .SCK(sck), .SI(si),
    .SO(so), .SO_OE(so_oe), .RESET_N(rst_n), .WP_N(wp_n), .BUSY(busy),
    .WEN(wen), .ARR_WR(arr_wr), .ARR_ERASE_ALL(erase_all)
  );
  sfpe_host sfpe_host_i (.clk(clk), .cs_n(cs_n), .sck(sck), .si(si),
    .so(so), .so_oe(so_oe));
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic chk_wr(sfpe_arr_wr_s e, sfpe_arr_wr_s g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value array write exp %h got %h", e, g);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmd(logic [7:0] op);
    sfpe_host_i.sel();
    sfpe_host_i.xb(op, 8, rx);
    sfpe_host_i.desel();
  endtask
  // Host polls status until the busy bit drops
  task automatic wait_done();
    int n = 0;
    do begin
      sfpe_host_i.sel();
      sfpe_host_i.xb(OP_STATUS_READ, 8, rx);
      sfpe_host_i.xb(8'h00, 8, rx);
      sfpe_host_i.desel();
      n++;
    end while (rx[STAT_BUSY_BIT] !== 1'b0 && n < 200);
    chk("busy bit", 0, rx[STAT_BUSY_BIT]);
  endtask
  task automatic load(logic [7:0] op, logic [18:0] ad, int nb, int part,
      bit ex);
    logic rw = (op == OP_PAGE_WRITE);
    sfpe_host_i.sel();
    sfpe_host_i.xb(op, 8, rx);
    sfpe_host_i.xb({5'h0, ad[18:16]}, 8, rx);
    sfpe_host_i.xb(ad[15:8], 8, rx);
    sfpe_host_i.xb(ad[7:0], 8, rx);
    for (int i = 0; i < nb; i++) sfpe_host_i.xb(dat[i], 8, rx);
    if (part > 0) sfpe_host_i.xb(8'h5a, part, rx);
    // Notes go in before deselect: the commit walk starts a few cycles after
    // Slots come in ascending order; only the last 256 bytes count
    for (int s = 0; s < 256 && ex; s++)
      for (int k = nb - 1; k >= 0 && k >= nb - 256; k--)
        if (8'(ad[7:0] + k) == s)
          exp_q.push_back(sfpe_arr_wr_s'({1'b1, rw, ad[18:8], 8'(s),
            dat[k]}));
    sfpe_host_i.desel();
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      errors++;
      complete_run();
    end
    blen <= (busy === 1'b1) ? blen + 1 : 0;
    if (busy === 1'b1) blen_last <= blen + 1;
    if (erase_all === 1'b1) n_erase <= n_erase + 1;
    if (arr_wr.we === 1'b1) begin
      if (exp_q.size() == 0) chk("spare write", 0, 1);
      else chk_wr(exp_q.pop_front(), arr_wr);
    end
  end
  initial begin
    id_t = '{ID_MAKER_CODE, ID_PART_CODE, ID_FILLER};
    void'($urandom(95190));
    foreach (dat[i]) dat[i] = 8'($urandom);
    a = 19'($urandom) | 19'h10000;
    a[7:0] = 8'hff;
    repeat (6) @(negedge clk);
    rst = 0;
    // Write wait shortened to the read wait; the block keeps no power timer
    repeat (10000) @(negedge clk);
    sfpe_host_i.sel();
    sfpe_host_i.xb(OP_ID_READ, 8, rx);
    for (int i = 0; i < 6; i++) begin
      sfpe_host_i.xb(8'h00, 8, rx);
      chk("id byte", id_t[i % 3], rx);
    end
    sfpe_host_i.desel();
    chk("id release", 0, so_oe);
    $display("test id done");
    cmd(OP_WRITE_EN);
    chk("wen set", 1, wen);
    cmd(OP_WRITE_DIS);
    load(OP_PAGE_PROG, a, 2, 0, 0);
    wp_n = 0;
    cmd(OP_WRITE_EN);
    cmd(OP_CHIP_ERASE);
    load(OP_PAGE_PROG, a & 19'h0ffff, 2, 0, 0);
    chk("wen kept", 1, wen);
    load(OP_PAGE_PROG, a, 3, 0, 1);
    sfpe_host_i.sel();
    sfpe_host_i.xb(OP_ID_READ, 8, rx);
    sfpe_host_i.xb(8'h00, 8, rx);
    chk("id busy", 0, so_oe);
    sfpe_host_i.desel();
    rst_n = 0;
    repeat (10) @(negedge clk);
    rst_n = 1;
    chk("busy kept", 1, busy);
    wait_done();
    chk("prog time", 1, 32'(blen_last >= 5710 && blen_last <= 6110));
    chk("wen end", 0, wen);
    wp_n = 1;
    $display("test program done");
    cmd(OP_WRITE_EN);
    load(OP_PAGE_PROG, a, 1, 4, 0);
    chk("wen partial", 1, wen);
    sfpe_host_i.sel();
    sfpe_host_i.xb(OP_ID_READ, 8, rx);
    sfpe_host_i.xb(8'h00, 8, rx);
    rst_n = 0;
    repeat (10) @(negedge clk);
    chk("so in reset", 0, so_oe);
    chk("wen reset", 0, wen);
    rst_n = 1;
    sfpe_host_i.desel();
    $display("test reset done");
    cmd(OP_WRITE_EN);
    cmd(OP_CHIP_ERASE);
    wait_done();
    chk("erase count", 1, n_erase);
    chk("erase time", 1, 32'(blen_last >= 200 && blen_last <= 260));
    $display("test erase done");
    a = 19'($urandom) | 19'h20000;
    cmd(OP_WRITE_EN);
    load(OP_PAGE_WRITE, a, 2, 0, 1);
    wait_done();
    cmd(OP_WRITE_EN);
    load(OP_PAGE_WRITE, a, 258, 0, 1);
    wait_done();
    chk("write time", 1, 32'(blen_last >= 300 && blen_last <= 1000));
    chk("pending", 0, exp_q.size());
    chk("wen write", 0, wen);
    $display("test page write done");
    complete_run();
  end
endmodule // tb
